/* File: design/afc_pkg.sv */
// ****************************************************************
// Shared constants for the frame, channel and power control block.
// ****************************************************************
package afc_pkg;

  // Width of one conversion result.
  localparam int unsigned CODE_W       = 10;
  // Number of code steps across the analog supply span.
  localparam int unsigned CODE_STEPS   = 1024;
  // Width of the channel select field and number of inputs.
  localparam int unsigned CHAN_W       = 3;
  localparam int unsigned CHAN_COUNT   = 8;
  // Width of the serial control word.
  localparam int unsigned CTRL_W       = 8;
  // Width of the per-conversion clock counters.
  localparam int unsigned CNT_W        = 4;

  // Cycle figures inside one 16-clock conversion.
  localparam logic [3:0] CNT_LAST_RISE = 4'hf;  // 16th rising edge, counter value 15.
  localparam logic [3:0] CNT_CTRL_LAST = 4'h7;  // 8th rising edge, last control bit.
  localparam logic [3:0] CNT_LAST_FALL = 4'hf;  // Count before the 16th falling edge.
  localparam logic [3:0] CNT_HOLD_FALL = 4'h4;  // Count after the 4th falling edge.
  localparam logic [3:0] EDGE_MSB      = 4'h5;  // Falling edge carrying the MSB.
  localparam logic [3:0] EDGE_LSB      = 4'he;  // Falling edge carrying the LSB.
  localparam logic [3:0] CNT_ZERO      = 4'h0;
  localparam logic [3:0] CNT_ONE       = 4'h1;

  // Position of the channel field in the control word.
  localparam int unsigned CHAN_FIELD_HI = 5;
  localparam int unsigned CHAN_FIELD_LO = 3;

  // Reset values.
  localparam logic [2:0] CHAN_RESET    = 3'h0;
  localparam logic [9:0] CODE_RESET    = 10'h000;
  localparam logic [7:0] CTRL_RESET    = 8'h00;

endpackage : afc_pkg

/* File: design/afc_sync.sv */
`timescale 1ns/1ps
// ****************************************************************
// Two flip-flop synchroniser for single-bit levels.
// ****************************************************************
module afc_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_q   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : afc_sync

/* File: design/afc_top.sv */
`timescale 1ns/1ps
// Functional notes
// - Three-bit field picks input 0..7, default 0.
// - Result code is plain unsigned straight binary.
// - Ten-bit code, step is supply over 1024.
// - Powered while select low, down while high.
// - Auto power-down from 16th to next 1st fall.
// - Conversions of 16 clocks run back to back.
// - Eight rising-edge control bits, bits 5..3 channel.
// - Falls 1-4 zero, 5-14 result MSB first, 15-16 zero.
// - Output tristated and clock ignored while deselected.
// - Track three cycles, hold thirteen cycles.

// ****************************************************************
// Serial frame, channel select and power control.
// ****************************************************************
module afc_top (
  input  wire logic                       clk_sys,
  input  wire logic                       reset_n,
  input  wire logic                       link_sclk,
  input  wire logic                       cs_n,
  input  wire logic                       din,
  output logic                            dout,
  output logic                            dout_oe,
  input  wire logic [afc_pkg::CODE_W-1:0] sar_code,
  output logic      [afc_pkg::CHAN_W-1:0] mux_chan,
  output logic                            track,
  output logic                            power_up,
  output logic                            sys_power_up,
  output logic                            result_valid,
  output logic      [afc_pkg::CODE_W-1:0] result_code,
  output logic      [afc_pkg::CHAN_W-1:0] result_chan
);
  import afc_pkg::*;

  // ****************************************************************
  // Link domain: frame counters.
  // ****************************************************************
  logic                frame_rst_n;
  logic [CNT_W-1:0]    rise_cnt_q;
  logic [CNT_W-1:0]    fall_cnt_q;
  logic [CNT_W-1:0]    fall_edge;
  logic                pd_gap_q;
  logic [CTRL_W-1:0]   ctrl_q;
  logic [CHAN_W-1:0]   pend_chan_q;
  logic [CHAN_W-1:0]   chan_q;
  logic [CODE_W-1:0]   code_q;
  logic [CHAN_W-1:0]   conv_chan_q;
  logic                dout_q;
  logic                res_tgl_q;

  // The frame logic is held cleared while the select pin is high, so the
  // clock has no effect between frames.
  assign frame_rst_n = reset_n & ~cs_n;

  // Number of the falling edge that is about to occur, 1..16 with 16 as 0.
  assign fall_edge = CNT_W'(fall_cnt_q + CNT_ONE);

  // Rising edges counted modulo 16; each wrap starts the next conversion.
  always_ff @(posedge link_sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      rise_cnt_q <= CNT_ZERO;
    end
    else
    begin
      rise_cnt_q <= CNT_W'(rise_cnt_q + CNT_ONE);
    end
  end

  // Falling edges counted modulo 16 within each conversion.
  always_ff @(negedge link_sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      fall_cnt_q <= CNT_ZERO;
    end
    else
    begin
      fall_cnt_q <= fall_edge;
    end
  end

  // Power-down gap between back-to-back conversions: set on the 16th
  // falling edge, cleared on the 1st falling edge of the next one.
  always_ff @(negedge link_sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      pd_gap_q <= 1'b0;
    end
    else if (fall_cnt_q == CNT_LAST_FALL)
    begin
      pd_gap_q <= 1'b1;
    end
    else
    begin
      pd_gap_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Link domain: control word and channel select.
  // ****************************************************************

  // Control bits shift in MSB first on the first eight rising edges.
  always_ff @(posedge link_sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      ctrl_q <= CTRL_RESET;
    end
    else if (rise_cnt_q <= CNT_CTRL_LAST)
    begin
      ctrl_q <= {ctrl_q[CTRL_W-2:0], din};
    end
  end

  // The channel field is captured on the 8th rising edge and applied at
  // the 16th, so it steers the next conversion only. The selection is kept
  // across frames and only a system reset returns it to input 0.
  always_ff @(posedge link_sclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pend_chan_q <= CHAN_RESET;
      chan_q      <= CHAN_RESET;
    end
    else if (!cs_n)
    begin
      if (rise_cnt_q == CNT_CTRL_LAST)
      begin
        // Bits 5..3 of the full word sit one place lower before din lands.
        pend_chan_q <= ctrl_q[CHAN_FIELD_HI-1:CHAN_FIELD_LO-1];
      end
      if (rise_cnt_q == CNT_LAST_RISE)
      begin
        chan_q <= pend_chan_q;
      end
    end
  end

  // Binary index drives the analog multiplexer directly.
  assign mux_chan = chan_q;

  // ****************************************************************
  // Link domain: sampling and power.
  // ****************************************************************

  // Track during the first three cycles, hold for the other thirteen.
  assign track = ~cs_n & ~pd_gap_q & (fall_cnt_q < CNT_HOLD_FALL);

  // Fully powered inside a frame except in the gap between conversions.
  assign power_up = ~cs_n & ~pd_gap_q;

  // The held code is taken at the start of hold along with its channel.
  // It is passed on unchanged: unsigned straight binary, CODE_STEPS steps.
  always_ff @(negedge link_sclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      code_q      <= CODE_RESET;
      conv_chan_q <= CHAN_RESET;
    end
    else if (!cs_n && fall_edge == CNT_HOLD_FALL)
    begin
      code_q      <= sar_code;
      conv_chan_q <= chan_q;
    end
  end

  // ****************************************************************
  // Link domain: serial data output.
  // ****************************************************************

  // Leading zeros, result MSB first on edges 5..14, trailing zeros.
  always_ff @(negedge link_sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      dout_q <= 1'b0;
    end
    else if (fall_edge >= EDGE_MSB && fall_edge <= EDGE_LSB)
    begin
      dout_q <= code_q[CNT_W'(EDGE_LSB - fall_edge)];
    end
    else
    begin
      dout_q <= 1'b0;
    end
  end

  assign dout    = dout_q;
  assign dout_oe = ~cs_n;

  // ****************************************************************
  // Crossing of results and power state to the system clock.
  // ****************************************************************

  // Toggled on the edge after capture; the code and channel then stay
  // stable for a whole conversion, far longer than the system side needs.
  always_ff @(negedge link_sclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      res_tgl_q <= 1'b0;
    end
    else if (!cs_n && fall_edge == EDGE_MSB)
    begin
      res_tgl_q <= ~res_tgl_q;
    end
  end

  logic res_tgl_sync;
  logic res_tgl_seen_q;

  afc_sync #(
    .RESET_VAL (1'b0)
  ) u_sync_result (
    .clk      (clk_sys),
    .reset_n  (reset_n),
    .async_in (res_tgl_q),
    .sync_out (res_tgl_sync)
  );

  afc_sync #(
    .RESET_VAL (1'b0)
  ) u_sync_power (
    .clk      (clk_sys),
    .reset_n  (reset_n),
    .async_in (power_up),
    .sync_out (sys_power_up)
  );

  // A change of the synchronised toggle latches the stable result word.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      res_tgl_seen_q <= 1'b0;
      result_valid   <= 1'b0;
      result_code    <= CODE_RESET;
      result_chan    <= CHAN_RESET;
    end
    else
    begin
      res_tgl_seen_q <= res_tgl_sync;
      result_valid   <= res_tgl_sync ^ res_tgl_seen_q;
      if (res_tgl_sync ^ res_tgl_seen_q)
      begin
        result_code <= code_q;
        result_chan <= conv_chan_q;
      end
    end
  end

endmodule : afc_top

/* File: verification/adc_frame_chan_power_ctrl_tb.sv */
`timescale 1ns/1ps
// **********
// Self-checking bench.
// **********
module adc_frame_chan_power_ctrl_tb;
  logic        clk_sys, reset_n, link_sclk, cs_n, din, dout, dout_oe, track, power_up;
  logic        sys_power_up, result_valid;
  logic [9:0]  sar_code, result_code, val [8];
  logic [2:0]  mux_chan, result_chan;
  logic [7:0]  ctl;
  logic [15:0] word, q_exp [$];
  int          n_fail, cmp_count, cyc, ch, seq;
  afc_top dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .link_sclk(link_sclk), .cs_n(cs_n),
    .din(din), .dout(dout), .dout_oe(dout_oe), .sar_code(sar_code), .mux_chan(mux_chan),
    .track(track), .power_up(power_up), .sys_power_up(sys_power_up),
    .result_valid(result_valid), .result_code(result_code), .result_chan(result_chan));
  afc_host host_u (.cs_n(cs_n), .link_sclk(link_sclk), .din(din), .dout(dout));
  // Analog core: each input holds a fixed code per frame.
  assign sar_code = val[mux_chan];
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Hang limit and a check of every reported result in conversion order.
  always @(negedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      summarize();
    end
    if (result_valid === 1'b1)
      chk({3'h0, result_chan, result_code}, q_exp.size() ? q_exp.pop_front() : 16'hffff);
  end
  // Frames of one to four back-to-back conversions walk through all channels.
  initial
  begin
    reset_n = 1'b0;
    void'($urandom(87));
    for (int k = 0; k < 8; k++) val[k] = 10'h000;
    repeat (16) @(negedge clk_sys);
    reset_n = 1'b1;
    chk(16'(mux_chan), 16'h0000);
    for (int r = 0; r < 4; r++)
    begin
      @(negedge clk_sys);
      for (int k = 0; k < 8; k++) val[k] = (r == 1) ? {10{k[0]}} : 10'($urandom);
      #3;
      host_u.open_frame();
      for (int n = 0; n <= r; n++)
      begin
        ctl = {2'($urandom), 3'(seq), 3'($urandom)};
        seq++;
        q_exp.push_back({3'h0, 3'(ch), val[ch]});
        host_u.conv(ctl, word);
        chk(word, {4'h0, val[ch], 2'h0});
        ch = int'(ctl[5:3]);
        chk(16'(mux_chan), 16'(ch));
      end
      host_u.close_frame();
      repeat (6) @(negedge clk_sys);
      chk({13'h0000, sys_power_up, dout_oe, power_up}, 16'h0000);
    end
    chk(16'(q_exp.size()), 16'h0000);
    summarize();
  end
endmodule : adc_frame_chan_power_ctrl_tb

/* File: verification/afc_host.sv */
`timescale 1ns/1ps
// **********
// Host serial controller model.
// **********
module afc_host (
  output logic      cs_n,
  output logic      link_sclk,
  output logic      din,
  input  wire logic dout
);
  // Idle: deselected, clock standing high.
  initial
  begin
    cs_n = 1'b1;
    link_sclk = 1'b1;
    din = 1'b0;
  end
  // One 16-clock conversion; control goes out MSB first, then din toggles.
  task automatic conv(input logic [7:0] ctl, output logic [15:0] word);
    for (int i = 0; i < 16; i++)
    begin
      link_sclk = 1'b0;
      din = (i < 8) ? ctl[7 - i] : ~din;
      #80;
      link_sclk = 1'b1;
      word = {word[14:0], dout};
      #80;
    end
  endtask : conv
  task automatic open_frame;
    cs_n = 1'b0;
    #80;
  endtask : open_frame
  // Ends on a conversion boundary, then pulses the clock while deselected.
  task automatic close_frame;
    cs_n = 1'b1;
    din = ~din;
    repeat (2)
    begin
      #80 link_sclk = 1'b0;
      #80 link_sclk = 1'b1;
    end
  endtask : close_frame
endmodule : afc_host

/* File: verification/afc_monitor.sv */
`timescale 1ns/1ps
// **********
// Link and power checker.
// **********
module afc_monitor (
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic       link_sclk,
  input wire logic       cs_n,
  input wire logic       dout,
  input wire logic       dout_oe,
  input wire logic [9:0] sar_code,
  input wire logic [2:0] mux_chan,
  input wire logic       track,
  input wire logic       power_up,
  input wire logic       result_valid
);
  logic [4:0] fc_q;
  logic [9:0] cap_q;
  // Counts link falls in the frame; 16 marks the power-down gap.
  always_ff @(negedge link_sclk or posedge cs_n or negedge reset_n)
    if (!reset_n || cs_n) fc_q <= 5'h00;
    else fc_q <= (fc_q == 5'h10) ? 5'h01 : fc_q + 5'h01;
  // Holds the code that the fourth fall takes.
  always_ff @(negedge link_sclk)
    if (fc_q == 5'h03) cap_q <= sar_code;
  property p_zero;
    @(posedge link_sclk) disable iff (!reset_n || cs_n) !(fc_q inside {[5:14]}) |-> !dout;
  endproperty
  a_zero: assert property (p_zero) else $error("dout not zero outside the result");
  property p_data;
    @(posedge link_sclk) disable iff (!reset_n || cs_n)
      fc_q inside {[5:14]} |-> dout == cap_q[5'h0e - fc_q];
  endproperty
  a_data: assert property (p_data) else $error("result bit out of order");
  property p_track;
    @(posedge link_sclk) disable iff (!reset_n || cs_n) track == (fc_q < 5'h04);
  endproperty
  a_track: assert property (p_track) else $error("track window wrong");
  property p_gap;
    @(posedge link_sclk) disable iff (!reset_n || cs_n) power_up == (fc_q != 5'h10);
  endproperty
  a_gap: assert property (p_gap) else $error("power gap wrong");
  property p_chan;
    @(posedge link_sclk) disable iff (!reset_n || cs_n) $changed(mux_chan) |-> fc_q == 5'h01;
  endproperty
  a_chan: assert property (p_chan) else $error("channel changed mid conversion");
  property p_oe;
    @(posedge clk_sys) disable iff (!reset_n) dout_oe == !cs_n;
  endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");
  property p_off;
    @(posedge clk_sys) disable iff (!reset_n) cs_n |-> !power_up && !track && !dout;
  endproperty
  a_off: assert property (p_off) else $error("powered while deselected");
  property p_pulse;
    @(posedge clk_sys) disable iff (!reset_n) result_valid |=> !result_valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("result pulse too long");
  property p_rst;
    @(posedge clk_sys) disable iff (!reset_n) $rose(reset_n) |-> mux_chan == 3'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("default channel not zero");
  c_res: cover property (@(posedge clk_sys) result_valid);
  c_gap: cover property (@(posedge link_sclk) fc_q == 5'h10 && !cs_n);
  c_chan: cover property (@(posedge link_sclk) $changed(mux_chan));
endmodule : afc_monitor

bind afc_top afc_monitor mon_u (
  .clk_sys(clk_sys), .reset_n(reset_n), .link_sclk(link_sclk), .cs_n(cs_n), .dout(dout),
  .dout_oe(dout_oe), .sar_code(sar_code), .mux_chan(mux_chan), .track(track),
  .power_up(power_up), .result_valid(result_valid));
